// ===== fa_port.v
/*
 Fast A20 gate and CPU reset port with its enable configuration, reached
 over AXI4-Lite. Combines the fast signals with the keyboard controller's
 A20 gate and reset. Assumes all inputs synchronous to aclk and aresetn
 wired to the host bus reset.
*/
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "fa_defs.vh"

module fa_port #(
   parameter ADDR_W   = 12,
   parameter DELAY_NS = `FA_DELAY_NS,
   parameter WIDTH_NS = `FA_WIDTH_NS,
   parameter CLK_MHZ  = `FA_CLK_MHZ
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire              kbc_port_a20_bit,
   input  wire              kbc_reset_n,
   input  wire              cpu_reset_in,
   output reg               fast_a20_ctl,
   output wire              fast_cpu_reset_n,
   output reg               cpu_a20_mask_n,
   output reg               kbc_a20_gate,
   output reg               combined_cpu_reset
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   localparam [2:0] SEL_NONE = 3'd0;
   localparam [2:0] SEL_PORT = 3'd1;
   localparam [2:0] SEL_CFG  = 3'd2;
   localparam [2:0] SEL_CTRL = 3'd3;
   localparam [2:0] SEL_STAT = 3'd4;

   function [2:0] fa_decode;
      input [ADDR_W-1:0] addr;
      begin
         case (addr)
            `FA_ADDR_PORT: fa_decode = SEL_PORT;
            `FA_ADDR_CFG:  fa_decode = SEL_CFG;
            `FA_ADDR_CTRL: fa_decode = SEL_CTRL;
            `FA_ADDR_STAT: fa_decode = SEL_STAT;
            default:       fa_decode = SEL_NONE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register state

   reg [7:0]        kbd_reset_a20_config;
   reg              rst_req;
   reg              reset_polarity;
   wire             port_enabled;
   wire             pulse_busy;
   wire             pulse_n;

   assign port_enabled = kbd_reset_a20_config[`FA_CFG_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order

   reg              aw_held;
   reg [ADDR_W-1:0] aw_addr;
   reg              w_held;
   reg [31:0]       w_data;
   reg [3:0]        w_strb;
   wire             do_write;
   wire [2:0]       wr_sel;
   wire             wr_lane0;
   reg  [1:0]       next_bresp;

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_sel   = fa_decode(aw_addr);
   assign wr_lane0 = w_strb[0];

   always @* begin
      case (wr_sel)
         SEL_PORT: next_bresp = port_enabled ? `FA_RESP_OKAY : `FA_RESP_DECERR;
         SEL_CFG:  next_bresp = `FA_RESP_OKAY;
         SEL_CTRL: next_bresp = `FA_RESP_OKAY;
         SEL_STAT: next_bresp = `FA_RESP_OKAY;
         default:  next_bresp = `FA_RESP_DECERR;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FA_RESP_OKAY;
         aw_held       <= 1'b0;
         aw_addr       <= {ADDR_W{1'b0}};
         w_held        <= 1'b0;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_bresp;
         end
         // Both channels reopen only after the response is taken
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software-visible registers

   wire port_write;
   wire rise_req;

   assign port_write = do_write && wr_lane0 && (wr_sel == SEL_PORT) && port_enabled;
   // Only a 0 to 1 change of the stored bit starts a pulse
   assign rise_req = port_write && w_data[`FA_PORT_RST_BIT] && !rst_req;

   always @(posedge aclk) begin
      if (!aresetn) begin
         kbd_reset_a20_config <= `FA_CFG_RESET;
         fast_a20_ctl         <= 1'b0;
         rst_req              <= 1'b0;
         reset_polarity       <= 1'b0;
      end else begin
         if (do_write && wr_lane0 && (wr_sel == SEL_CFG)) begin
            kbd_reset_a20_config <= w_data[7:0];
         end
         if (do_write && wr_lane0 && (wr_sel == SEL_CTRL)) begin
            reset_polarity <= w_data[`FA_CTRL_POL_BIT];
         end
         if (port_write) begin
            fast_a20_ctl <= w_data[`FA_PORT_A20_BIT];
            rst_req      <= w_data[`FA_PORT_RST_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pulse generator

   fa_pulse #(
      .DELAY_NS (DELAY_NS),
      .WIDTH_NS (WIDTH_NS),
      .CLK_MHZ  (CLK_MHZ),
      .CNT_W    (16)
   ) u_pulse (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .trigger  (rise_req),
      .pulse_n  (pulse_n),
      .busy     (pulse_busy)
   );

   assign fast_cpu_reset_n = pulse_n;

   ////////////////////////////////////////////////////////////////////////
   // Combined outputs, registered

   always @(posedge aclk) begin
      if (!aresetn) begin
         kbc_a20_gate       <= 1'b0;
         cpu_a20_mask_n     <= 1'b0;
         combined_cpu_reset <= 1'b1;
      end else begin
         kbc_a20_gate   <= kbc_port_a20_bit;
         cpu_a20_mask_n <= kbc_port_a20_bit | fast_a20_ctl | cpu_reset_in;
         // Fast pulse only joins while the port is enabled
         if (port_enabled) begin
            combined_cpu_reset <= reset_polarity ^ (pulse_n & kbc_reset_n);
         end else begin
            combined_cpu_reset <= reset_polarity ^ kbc_reset_n;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel

   wire [2:0] rd_sel;
   reg [31:0] next_rdata;
   reg [1:0]  next_rresp;

   assign rd_sel = fa_decode(s_axi_araddr);

   always @* begin
      next_rdata = 32'h00000000;
      next_rresp = `FA_RESP_OKAY;
      case (rd_sel)
         SEL_PORT: begin
            if (port_enabled) begin
               next_rdata[7:0] = `FA_PORT_FIXED;
               next_rdata[`FA_PORT_A20_BIT] = fast_a20_ctl;
               next_rdata[`FA_PORT_RST_BIT] = rst_req;
            end else begin
               next_rresp = `FA_RESP_DECERR;
            end
         end
         SEL_CFG: begin
            next_rdata[7:0] = kbd_reset_a20_config;
         end
         SEL_CTRL: begin
            next_rdata[`FA_CTRL_POL_BIT] = reset_polarity;
         end
         SEL_STAT: begin
            next_rdata[`FA_STAT_RSTN_BIT] = pulse_n;
            next_rdata[`FA_STAT_BUSY_BIT] = pulse_busy;
            next_rdata[`FA_STAT_MASK_BIT] = cpu_a20_mask_n;
            next_rdata[`FA_STAT_KRST_BIT] = combined_cpu_reset;
            next_rdata[`FA_STAT_A20_BIT]  = kbc_a20_gate;
         end
         default: begin
            next_rresp = `FA_RESP_DECERR;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `FA_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ===== fa_defs.vh
/*
 Constants for the fast A20 gate and CPU reset port: register indices and
 byte addresses, field positions, reset values, bus answers and pulse times.
 Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
*/
`ifndef FA_DEFS_VH
`define FA_DEFS_VH

// Register indices; byte address is four times the index
`define FA_IDX_PORT      10'h092
`define FA_IDX_CFG       10'h0F0
`define FA_IDX_CTRL      10'h200
`define FA_IDX_STAT      10'h201
`define FA_ADDR_PORT     {`FA_IDX_PORT, 2'b00}
`define FA_ADDR_CFG      {`FA_IDX_CFG, 2'b00}
`define FA_ADDR_CTRL     {`FA_IDX_CTRL, 2'b00}
`define FA_ADDR_STAT     {`FA_IDX_STAT, 2'b00}

// Fast control port fields
`define FA_PORT_RESET    8'h24
`define FA_PORT_FIXED    8'h24
`define FA_PORT_RST_BIT  0
`define FA_PORT_A20_BIT  1

// Configuration, control and status fields
`define FA_CFG_RESET     8'h00
`define FA_CFG_EN_BIT    2
`define FA_CTRL_POL_BIT  0
`define FA_STAT_RSTN_BIT 0
`define FA_STAT_BUSY_BIT 1
`define FA_STAT_MASK_BIT 2
`define FA_STAT_KRST_BIT 3
`define FA_STAT_A20_BIT  4

// Bus answers
`define FA_RESP_OKAY     2'b00
`define FA_RESP_DECERR   2'b11

// Pulse timing
`define FA_CLK_MHZ       100
`define FA_DELAY_NS      14000
`define FA_WIDTH_NS      6000

`endif

// ===== fa_pulse.v
/*
 One-shot generator for the active-low fast CPU reset: waits a least delay,
 then drives the output low for a least width, then returns high.
 Assumes a one-cycle trigger and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "fa_defs.vh"

module fa_pulse #(
   parameter DELAY_NS = `FA_DELAY_NS,
   parameter WIDTH_NS = `FA_WIDTH_NS,
   parameter CLK_MHZ  = `FA_CLK_MHZ,
   parameter CNT_W    = 16
) (
   input  wire aclk,
   input  wire aresetn,
   input  wire trigger,
   output reg  pulse_n,
   output reg  busy
);

   // Least times round up to whole cycles
   localparam integer     DELAY_INT = (DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam integer     WIDTH_INT = (WIDTH_NS * CLK_MHZ + 999) / 1000;
   // Counter width bounds the longest time; cut to it on purpose
   localparam [CNT_W-1:0] DELAY_CYC = DELAY_INT[CNT_W-1:0];
   localparam [CNT_W-1:0] WIDTH_CYC = WIDTH_INT[CNT_W-1:0];
   localparam [CNT_W-1:0] ONE       = 1;

   localparam [1:0] ST_IDLE  = 2'b00;
   localparam [1:0] ST_DELAY = 2'b01;
   localparam [1:0] ST_LOW   = 2'b10;

   reg [1:0]       state;
   reg [CNT_W-1:0] count;

   ////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      if (!aresetn) begin
         state   <= ST_IDLE;
         count   <= {CNT_W{1'b0}};
         pulse_n <= 1'b1;
         busy    <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (trigger) begin
                  state <= ST_DELAY;
                  count <= DELAY_CYC - ONE;
                  busy  <= 1'b1;
               end
            end
            ST_DELAY: begin
               if (count == {CNT_W{1'b0}}) begin
                  state   <= ST_LOW;
                  count   <= WIDTH_CYC - ONE;
                  pulse_n <= 1'b0;
               end else begin
                  count <= count - ONE;
               end
            end
            ST_LOW: begin
               if (count == {CNT_W{1'b0}}) begin
                  state   <= ST_IDLE;
                  pulse_n <= 1'b1;
                  busy    <= 1'b0;
               end else begin
                  count <= count - ONE;
               end
            end
            default: begin
               state   <= ST_IDLE;
               pulse_n <= 1'b1;
               busy    <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ===== fa_port_checker.sv
/*
 Assertions on the fast A20 and CPU reset port, seen from its pins.
 Assumes binding to fa_port with its timing parameters handed on.
*/
`timescale 1ns/10ps
`include "fa_defs.vh"
module fa_port_checker #(
   parameter ADDR_W   = 12,
   parameter DELAY_NS = `FA_DELAY_NS,
   parameter WIDTH_NS = `FA_WIDTH_NS,
   parameter CLK_MHZ  = `FA_CLK_MHZ
) (
   input wire              aclk,
   input wire              aresetn,
   input wire              s_axi_awvalid,
   input wire              s_axi_awready,
   input wire              s_axi_wvalid,
   input wire              s_axi_wready,
   input wire              s_axi_bvalid,
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire              s_axi_arvalid,
   input wire              s_axi_arready,
   input wire [31:0]       s_axi_rdata,
   input wire [1:0]        s_axi_rresp,
   input wire              s_axi_rvalid,
   input wire              kbc_port_a20_bit,
   input wire              cpu_reset_in,
   input wire              fast_a20_ctl,
   input wire              fast_cpu_reset_n,
   input wire              cpu_a20_mask_n,
   input wire              kbc_a20_gate
);
   localparam int D = DELAY_NS * CLK_MHZ / 1000;
   localparam int W = WIDTH_NS * CLK_MHZ / 1000;
   logic [15:0] since_b;
   logic [15:0] low_cnt;
   logic        rd_port;
   logic        bv_q;
   ////////////////////////////////////////
   // Only the latest write answer times the pulse
   always @(posedge aclk) begin
      if (!aresetn) begin
         since_b <= 16'h0000;
         low_cnt <= 16'h0000;
         rd_port <= 1'b0;
         bv_q    <= 1'b0;
      end else begin
         bv_q    <= s_axi_bvalid;
         since_b <= (s_axi_bvalid && !bv_q) ? 16'h0000 : since_b + 16'h0001;
         low_cnt <= fast_cpu_reset_n ? 16'h0000 : low_cnt + 16'h0001;
         if (s_axi_arvalid && s_axi_arready) begin
            rd_port <= (s_axi_araddr == `FA_ADDR_PORT);
         end
      end
   end
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_mask_or: assert property ($past(aresetn) |->
      cpu_a20_mask_n == $past(kbc_port_a20_bit | fast_a20_ctl | cpu_reset_in))
      else $error("a20 mask not the OR of its sources");
   a_gate_copy: assert property ($past(aresetn) |->
      kbc_a20_gate == $past(kbc_port_a20_bit)) else $error("a20 gate copy wrong");
   a_reset_state: assert property (disable iff (1'b0) !aresetn |=>
      !fast_a20_ctl && fast_cpu_reset_n && !cpu_a20_mask_n && !s_axi_rvalid)
      else $error("outputs not in reset state");
   a_pulse_width: assert property ($rose(fast_cpu_reset_n) |->
      low_cnt == W) else $error("reset pulse width wrong");
   a_pulse_delay: assert property ($fell(fast_cpu_reset_n) |->
      since_b >= D - 1 && since_b <= D + 1) else $error("reset pulse delay wrong");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write answer");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("no read answer");
   a_port_fixed: assert property (s_axi_rvalid && rd_port && s_axi_rresp == 2'b00 |->
      s_axi_rdata[31:8] == 24'h000000 && s_axi_rdata[7:2] == 6'b001001)
      else $error("fixed port bits wrong");
endmodule

// ===== fa_kbc_model.sv
/*
 Keyboard controller stand-in: A20 port bit, its reset and the CPU reset.
 Assumes the bench sets cmd just after a clock edge.
*/
`timescale 1ns/10ps
module fa_kbc_model (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire [2:0] cmd,
   output reg        kbc_port_a20_bit,
   output reg        kbc_reset_n,
   output reg        cpu_reset_in
);
   always @(posedge aclk) begin
      if (!aresetn) begin
         kbc_port_a20_bit <= 1'b0;
         kbc_reset_n      <= 1'b1;
         cpu_reset_in     <= 1'b0;
      end else begin
         kbc_port_a20_bit <= cmd[0];
         kbc_reset_n      <= ~cmd[1];
         cpu_reset_in     <= cmd[2];
      end
   end
endmodule

// ===== test_fast_a20_and_cpu_reset_port.sv
/*
 Bench for the fast A20 and CPU reset port: register bus master, scenarios.
 Assumes short pulse timing: 5 cycles delay, 3 cycles width.
*/
`timescale 1ns/10ps
`include "fa_defs.vh"
module test_fast_a20_and_cpu_reset_port;
   localparam [11:0] AP = `FA_ADDR_PORT;
   localparam [11:0] AC = `FA_ADDR_CFG;
   localparam [11:0] AK = `FA_ADDR_CTRL;
   localparam [1:0]  OK = `FA_RESP_OKAY;
   localparam [1:0]  DE = `FA_RESP_DECERR;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [2:0] cmd = 3'h0;
   wire awready, wready, bvalid, arready, rvalid, a20_bit, kbc_rst_n, cpu_rst;
   wire fast_a20_ctl, fast_cpu_reset_n, cpu_a20_mask_n, kbc_a20_gate, combined_cpu_reset;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int n_errors = 0, compares = 0;
   fa_port #(.DELAY_NS(50), .WIDTH_NS(30)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .kbc_port_a20_bit(a20_bit), .kbc_reset_n(kbc_rst_n),
      .cpu_reset_in(cpu_rst), .fast_a20_ctl(fast_a20_ctl),
      .fast_cpu_reset_n(fast_cpu_reset_n), .cpu_a20_mask_n(cpu_a20_mask_n),
      .kbc_a20_gate(kbc_a20_gate), .combined_cpu_reset(combined_cpu_reset));
   fa_kbc_model kbc_u (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
      .kbc_port_a20_bit(a20_bit), .kbc_reset_n(kbc_rst_n), .cpu_reset_in(cpu_rst));
   initial forever #5 aclk = ~aclk;
   ////////////////////////////////////////
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Both channels offered together; each dropped once taken
   task wr(input [11:0] a, input [7:0] d, input [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            chk("bresp", bresp, er);
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) chk("bvalid", 0, 1);
   endtask
   task rd(input [11:0] a, input [1:0] er, input [31:0] ed);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            chk("rresp", rresp, er);
            chk("rdata", rdata, ed);
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) chk("rvalid", 0, 1);
   endtask
   task pulse;
      int n;
      for (n = 0; n < 40 && fast_cpu_reset_n !== 1'b0; n++) @(posedge aclk);
      n = 0;
      while (fast_cpu_reset_n === 1'b0 && n < 20) begin
         n++;
         @(posedge aclk);
         if (n == 2) chk("combined", combined_cpu_reset, 0);
      end
      chk("width", n, 3);
   endtask
   ////////////////////////////////////////
   task t_disabled;
      rd(AP, DE, 0);
      wr(AP, 8'h03, DE);
      repeat (20) @(posedge aclk);
      chk("a20", fast_a20_ctl, 0);
      chk("fast_rst", fast_cpu_reset_n, 1);
      rd(12'h004, DE, 0);
   endtask
   task t_enable;
      rd(AC, OK, 0);
      wr(AC, 8'h04, OK);
      rd(AP, OK, 32'h24);
      wr(AP, 8'hFA, OK);
      rd(AP, OK, 32'h26);
      chk("a20", fast_a20_ctl, 1);
   endtask
   task t_mask;
      for (int i = 0; i < 8; i++) begin
         cmd <= {i[2], i[0], i[0]};
         wr(AP, {6'h00, i[1], 1'b0}, OK);
         repeat (3) @(posedge aclk);
         chk("mask", cpu_a20_mask_n, i != 0);
         chk("gate", kbc_a20_gate, i[0]);
         chk("combined", combined_cpu_reset, !i[0]);
      end
      wr(AK, 8'h01, OK);
      repeat (3) @(posedge aclk);
      chk("combined_inv", combined_cpu_reset, 1);
      wr(AK, 8'h00, OK);
      cmd <= 3'h0;
   endtask
   task t_pulse;
      wr(AP, 8'h01, OK);
      pulse();
      wr(AP, 8'h01, OK);
      repeat (20) @(posedge aclk);
      chk("no_rearm", fast_cpu_reset_n, 1);
      wr(AP, 8'h00, OK);
      wr(AP, 8'h01, OK);
      pulse();
   endtask
   task t_midreset;
      wr(AP, 8'h03, OK);
      rd(AP, OK, 32'h27);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk("a20", fast_a20_ctl, 0);
      rd(AC, OK, 0);
      rd(AP, DE, 0);
      wr(AC, 8'h04, OK);
      rd(AP, OK, 32'h24);
      wr(AP, 8'h01, OK);
      pulse();
   endtask
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_disabled();
      t_enable();
      t_mask();
      t_pulse();
      t_midreset();
      final_report();
   end
   // Whole run is a few hundred cycles
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
endmodule
bind fa_port fa_port_checker #(.ADDR_W(ADDR_W), .DELAY_NS(DELAY_NS), .WIDTH_NS(WIDTH_NS),
   .CLK_MHZ(CLK_MHZ)) chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .kbc_port_a20_bit(kbc_port_a20_bit),
   .cpu_reset_in(cpu_reset_in), .fast_a20_ctl(fast_a20_ctl),
   .fast_cpu_reset_n(fast_cpu_reset_n), .cpu_a20_mask_n(cpu_a20_mask_n),
   .kbc_a20_gate(kbc_a20_gate));
